// File: counter_sense.v
// universal counter pin control, count engine and voltage sense flip-flop
`timescale 1ns/10ps
`include "counter_sense_consts.vh"
module counter_sense #(
  parameter [`GATE_W-1:0] GATE_CYC0 = `GATE_CYC0_DEF,
  parameter [`GATE_W-1:0] GATE_CYC1 = `GATE_CYC1_DEF,
  parameter [`GATE_W-1:0] GATE_CYC2 = `GATE_CYC2_DEF,
  parameter [`GATE_W-1:0] GATE_CYC3 = `GATE_CYC3_DEF
) (
  // clock and power-on reset
  input  wire              sys_clk,
  input  wire              rst,
  // input pins
  input  wire              high_freq_counter_pin,
  input  wire              low_freq_counter_pin,
  input  wire              voltage_sense_pin,
  input  wire              hold_pin,
  // instruction strobes and operands
  input  wire              io_setup_instr,
  input  wire [3:0]        setup_word_selector,
  input  wire              counter_setup_instr,
  input  wire              count_time_instr,
  input  wire              counter_control_instr,
  input  wire              internal_reg_input_instr,
  input  wire              flag_test_instr,
  input  wire              clock_stop_instr,
  input  wire [3:0]        instr_data,
  input  wire [3:0]        reg_addr,
  input  wire              hold_enable_flag,
  // results
  output reg  [3:0]        read_data_q,
  output reg               read_valid_q,
  output reg  [3:0]        flag_data_q,
  output reg               flag_valid_q,
  output reg               count_done_flag,
  output reg               count_busy_q,
  output reg  [`CNT_W-1:0] count_value_q,
  output reg  [1:0]        mode_q,
  output reg               hf_gp_q,
  output reg               lf_gp_q,
  output reg               clock_stop_q
);

  // ****************************************
  // synchronised pin levels
  // ****************************************
  wire hf_raw;
  wire lf_raw;
  wire sense_lvl;
  wire hold_lvl;

  pin_sync u_sync_hf (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (high_freq_counter_pin),
    .level_q (hf_raw)
  );

  pin_sync u_sync_lf (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (low_freq_counter_pin),
    .level_q (lf_raw)
  );

  pin_sync u_sync_sense (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (voltage_sense_pin),
    .level_q (sense_lvl)
  );

  pin_sync u_sync_hold (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (hold_pin),
    .level_q (hold_lvl)
  );

  wire hf_lvl = hf_raw & ~clock_stop_q;
  wire lf_lvl = lf_raw & ~clock_stop_q;

  // ****************************************
  // clock stop control
  // ****************************************
  // wake follows the synchronised hold, so a short hold glitch cannot end the stop
  // enter and leave stop
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clock_stop_q <= 1'b0;
    end else if (clock_stop_q) begin
      if (hold_lvl) begin
        clock_stop_q <= 1'b0;
      end
    end else if (clock_stop_instr && hold_enable_flag && !hold_lvl) begin
      clock_stop_q <= 1'b1;
    end
  end

  // ****************************************
  // pin function and counter mode
  // ****************************************
  wire [1:0] mode_req = {instr_data[`BIT_MODE_HI], instr_data[`BIT_MODE_LO]};

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hf_gp_q <= 1'b0;
      lf_gp_q <= 1'b0;
      mode_q  <= `MODE_HF_FREQ;
    end else begin
      if (io_setup_instr && setup_word_selector == `SEL_COUNTER_PINS) begin
        hf_gp_q <= instr_data[`BIT_HF_GP];
        lf_gp_q <= instr_data[`BIT_LF_GP];
      end
      if (counter_setup_instr && mode_req != `MODE_RESERVED) begin
        mode_q <= mode_req;
      end
    end
  end

  // ****************************************
  // count time select
  // ****************************************
  reg [1:0]         time_sel_q;
  reg [`GATE_W-1:0] gate_len;

  // a new time may arrive mid-count; only the next start uses it
  // time chosen before start
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      time_sel_q <= 2'h0;
    end else if (count_time_instr) begin
      time_sel_q <= instr_data[`BIT_TIME_HI:`BIT_TIME_LO];
    end
  end

  always @* begin
    case (time_sel_q)
      2'h0:    gate_len = GATE_CYC0;
      2'h1:    gate_len = GATE_CYC1;
      2'h2:    gate_len = GATE_CYC2;
      default: gate_len = GATE_CYC3;
    endcase
  end

  // ****************************************
  // count engine
  // ****************************************
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_GATE = 2'h1;
  localparam [1:0] ST_ARM  = 2'h2;
  localparam [1:0] ST_PER  = 2'h3;

  reg  [1:0]         state_q;
  reg  [`GATE_W-1:0] gate_q;
  reg  [`CNT_W-1:0]  acc_q;
  reg                prev_q;
  // a pin in general-input use feeds no edges to the counter
  wire               sel_lvl = (mode_q == `MODE_HF_FREQ) ? (hf_lvl & ~hf_gp_q) : (lf_lvl & ~lf_gp_q);
  wire               rise    = sel_lvl & ~prev_q;
  wire               finish;
  wire               gate_end;
  wire               period_end;
  wire               start_ok = counter_control_instr && (state_q == ST_IDLE);
  // saturate rather than wrap, so an overlong period reads as all ones
  wire [`CNT_W-1:0]  acc_inc = (acc_q == `CNT_MAX) ? acc_q : acc_q + 1'b1;

  // gate ends when the down counter has run out
  assign gate_end   = (state_q == ST_GATE) && (gate_q == {`GATE_W{1'b0}});
  // period ends on the next rising edge or on saturation
  assign period_end = (state_q == ST_PER) && (rise || acc_q == `CNT_MAX);
  assign finish     = gate_end | period_end;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q       <= ST_IDLE;
      gate_q        <= {`GATE_W{1'b0}};
      acc_q         <= {`CNT_W{1'b0}};
      prev_q        <= 1'b0;
      count_value_q <= {`CNT_W{1'b0}};
      count_busy_q  <= 1'b0;
    end else begin
      prev_q <= sel_lvl;
      case (state_q)
        ST_IDLE: begin
          if (start_ok) begin
            acc_q        <= {`CNT_W{1'b0}};
            count_busy_q <= 1'b1;
            if (mode_q == `MODE_LF_PER) begin
              state_q <= ST_ARM;
            end else begin
              gate_q  <= gate_len - 1'b1;
              state_q <= ST_GATE;
            end
          end
        end
        ST_GATE: begin
          if (rise) begin
            acc_q <= acc_inc;
          end
          if (finish) begin
            count_value_q <= rise ? acc_inc : acc_q;
            count_busy_q  <= 1'b0;
            state_q       <= ST_IDLE;
          end else begin
            gate_q <= gate_q - 1'b1;
          end
        end
        ST_ARM: begin
          // period timing begins at the first rising edge
          if (rise) begin
            state_q <= ST_PER;
          end
        end
        ST_PER: begin
          if (finish) begin
            // the closing cycle counts, so a whole period is reported
            count_value_q <= acc_inc;
            count_busy_q  <= 1'b0;
            state_q       <= ST_IDLE;
          end else begin
            acc_q <= acc_inc;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // done flag, set wins over restart
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_done_flag <= 1'b0;
    end else if (finish) begin
      count_done_flag <= 1'b1;
    end else if (start_ok) begin
      count_done_flag <= 1'b0;
    end
  end

  // ****************************************
  // voltage sense flip-flop
  // ****************************************
  // reset means power was lost, so the flip-flop comes up set
  reg sense_ff_q;

  // low sense while stopped marks failure
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sense_ff_q <= 1'b1;
    end else if (clock_stop_q && !sense_lvl) begin
      sense_ff_q <= 1'b1;
    end else if (flag_test_instr) begin
      sense_ff_q <= 1'b0;
    end
  end

  // ****************************************
  // instruction reads
  // ****************************************
  // a pin left on the counter reads low, so a count input is never taken for a level
  reg [3:0] pin_level_word;
  reg [3:0] flag_word;

  always @* begin
    pin_level_word = `NIB_ZERO;
    flag_word      = `NIB_ZERO;
    pin_level_word[`BIT_RD_HF] = hf_lvl & hf_gp_q;
    pin_level_word[`BIT_RD_LF] = lf_lvl & lf_gp_q;
    flag_word[`BIT_FT_SENSE_FF] = sense_ff_q;
    flag_word[`BIT_FT_SENSE_LVL] = sense_lvl;
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      read_data_q  <= `NIB_ZERO;
      read_valid_q <= 1'b0;
      flag_data_q  <= `NIB_ZERO;
      flag_valid_q <= 1'b0;
    end else begin
      read_valid_q <= internal_reg_input_instr;
      flag_valid_q <= flag_test_instr;
      if (internal_reg_input_instr) begin
        // only the pin word is mapped
        read_data_q <= (reg_addr == `ADDR_PIN_LEVEL_E) ? pin_level_word : `NIB_ZERO;
      end
      if (flag_test_instr) begin
        flag_data_q <= flag_word;
      end
    end
  end

endmodule

// File: counter_sense_consts.vh
// constants for the universal counter and voltage sense input block
// Summary of operation
// - setup selector 3 with b3 clear routes the high-frequency pin to the counter.
// - setup selector 3 with b3 set makes the high-frequency pin a general input.
// - setup selector 3 with b2 clear routes the low-frequency pin to the counter.
// - setup selector 3 with b2 set makes the low-frequency pin a general input.
// - counter setup b3=0 b2=0 selects frequency measurement on the high-frequency pin.
// - counter setup b3=0 b2=1 selects frequency measurement on the low-frequency pin.
// - counter setup b3=1 b2=0 selects period measurement on the low-frequency pin.
// - count time is chosen first; only the control command starts a count.
// - a finished count, frequency or period, sets the count-done flag.
// - internal register 0x0e bit 0 returns the high-frequency pin level as input.
// - internal register 0x0e bit 1 returns the low-frequency pin level as input.
// - in clock stop both counter pins are disabled and read as low.
// - power-on reset selects counter function, high-frequency frequency mode.
// - a sense flip-flop fed by the sense pin records power failure, flag test bit 2.
// - the sense pin level as general input is flag test bit 3.
// - sense pin input stays enabled in clock stop; during reset its synchroniser is held cleared, so it reads low.
// - clock stop entered by hold enable, hold low and stop command; left on hold high.
`ifndef COUNTER_SENSE_CONSTS_VH
`define COUNTER_SENSE_CONSTS_VH

// ****************************************
// instruction fields
// ****************************************
`define SEL_COUNTER_PINS 4'h3
`define BIT_HF_GP        3
`define BIT_LF_GP        2
`define BIT_MODE_HI      3
`define BIT_MODE_LO      2
`define ADDR_PIN_LEVEL   4'h0
`define ADDR_PIN_LEVEL_E 4'h0e
`define BIT_RD_HF        0
`define BIT_RD_LF        1
`define BIT_FT_SENSE_FF  2
`define BIT_FT_SENSE_LVL 3
`define BIT_TIME_HI      1
`define BIT_TIME_LO      0

// ****************************************
// counter modes
// ****************************************
`define MODE_HF_FREQ  2'h0
`define MODE_LF_FREQ  2'h1
`define MODE_LF_PER   2'h2
`define MODE_RESERVED 2'h3

// ****************************************
// count times and widths
// ****************************************
// gate lengths in sys_clk cycles: 1, 4, 8 and 32 ms at 40 MHz
`define GATE_CYC0_DEF 21'h9c40
`define GATE_CYC1_DEF 21'h2_7100
`define GATE_CYC2_DEF 21'h4_e200
`define GATE_CYC3_DEF 21'h13_8800
`define CNT_W        20
`define GATE_W       21
`define CNT_MAX      20'hf_ffff
`define NIB_ZERO     4'h0

`endif

// File: counter_sense_sva.sv
// assertions on the counter and sense block ports
`timescale 1ns/10ps
module counter_sense_sva (
  // clock and reset
  input wire       sys_clk,
  input wire       rst,
  // instructions
  input wire       io_setup_instr,
  input wire [3:0] setup_word_selector,
  input wire       counter_setup_instr,
  input wire       counter_control_instr,
  input wire       internal_reg_input_instr,
  input wire       flag_test_instr,
  input wire       clock_stop_instr,
  input wire [3:0] instr_data,
  input wire [3:0] reg_addr,
  input wire       hold_enable_flag,
  // results
  input wire [3:0] read_data_q,
  input wire       read_valid_q,
  input wire       flag_valid_q,
  input wire       count_done_flag,
  input wire       count_busy_q,
  input wire [1:0] mode_q,
  input wire       hf_gp_q,
  input wire       lf_gp_q,
  input wire       clock_stop_q
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_hf_gp_set: assert property (io_setup_instr && setup_word_selector == 4'h3 && instr_data[3] |=> hf_gp_q)
    else $error("hf pin not general input");
  a_lf_route: assert property (io_setup_instr && setup_word_selector == 4'h3 && !instr_data[2] |=> !lf_gp_q)
    else $error("lf pin not routed to counter");
  a_sel_other: assert property (io_setup_instr && setup_word_selector != 4'h3 |=> $stable({hf_gp_q, lf_gp_q}))
    else $error("pin setup taken on wrong selector");
  a_period_mode: assert property (counter_setup_instr && instr_data[3:2] == 2'h2 |=> mode_q == 2'h2)
    else $error("period mode not set");
  a_reserved_mode: assert property (counter_setup_instr && instr_data[3:2] == 2'h3 |=> $stable(mode_q))
    else $error("reserved mode changed mode");
  a_start_busy: assert property (counter_control_instr && !count_busy_q |=> count_busy_q && !count_done_flag)
    else $error("start not taken");
  a_start_only: assert property ($rose(count_busy_q) |-> $past(counter_control_instr))
    else $error("count began without start");
  a_done_at_end: assert property ($fell(count_busy_q) |-> count_done_flag)
    else $error("done flag missing at end");
  a_unmapped_read: assert property (internal_reg_input_instr && reg_addr != 4'he |=> read_valid_q && read_data_q == 4'h0)
    else $error("unmapped read not zero");
  a_stop_pins_low: assert property (internal_reg_input_instr && clock_stop_q |=> read_data_q[1:0] == 2'h0)
    else $error("counter pins read high in stop");
  a_flag_pulse: assert property (flag_test_instr |=> flag_valid_q)
    else $error("flag test gave no answer");
  a_stop_refused: assert property (clock_stop_instr && !hold_enable_flag && !clock_stop_q |=> !clock_stop_q)
    else $error("stop entered without hold enable");
endmodule

bind counter_sense counter_sense_sva u_sva (
  .sys_clk(sys_clk), .rst(rst), .io_setup_instr(io_setup_instr),
  .setup_word_selector(setup_word_selector), .counter_setup_instr(counter_setup_instr),
  .counter_control_instr(counter_control_instr), .internal_reg_input_instr(internal_reg_input_instr),
  .flag_test_instr(flag_test_instr), .clock_stop_instr(clock_stop_instr), .instr_data(instr_data),
  .reg_addr(reg_addr), .hold_enable_flag(hold_enable_flag), .read_data_q(read_data_q),
  .read_valid_q(read_valid_q), .flag_valid_q(flag_valid_q), .count_done_flag(count_done_flag),
  .count_busy_q(count_busy_q), .mode_q(mode_q), .hf_gp_q(hf_gp_q), .lf_gp_q(lf_gp_q),
  .clock_stop_q(clock_stop_q)
);

// File: counter_sense_tb_top.sv
// testbench for the counter and sense block
`timescale 1ns/10ps
module counter_sense_tb_top;
  localparam int IO_SET = 0, MODE_SET = 1, TIME_SET = 2, START = 3, REG_RD = 4, FLAG_RD = 5, STOP = 6;
  logic        sys_clk = 1'b0, rst = 1'b1;
  logic        voltage_sense_pin = 1'b1, hold_pin = 1'b1, hold_enable_flag = 1'b0;
  logic        hf_run = 1'b0, lf_run = 1'b0, hf_lvl = 1'b0, lf_lvl = 1'b0;
  logic [6:0]  stb = 7'h0;
  logic [3:0]  setup_word_selector = 4'h0, instr_data = 4'h0, reg_addr = 4'h0;
  wire         high_freq_counter_pin, low_freq_counter_pin;
  wire         io_setup_instr, counter_setup_instr, count_time_instr, counter_control_instr;
  wire         internal_reg_input_instr, flag_test_instr, clock_stop_instr;
  wire [3:0]   read_data_q, flag_data_q;
  wire         read_valid_q, flag_valid_q, count_done_flag, count_busy_q, hf_gp_q, lf_gp_q, clock_stop_q;
  wire [19:0]  count_value_q;
  wire [1:0]   mode_q;
  int          error_cnt = 0, checks_done = 0;
  assign {clock_stop_instr, flag_test_instr, internal_reg_input_instr, counter_control_instr,
          count_time_instr, counter_setup_instr, io_setup_instr} = stb;
  always #12.5 sys_clk = ~sys_clk;
  pin_drive_model #(.HALF_NS(50)) u_pins (.hf_run(hf_run), .lf_run(lf_run), .hf_lvl(hf_lvl), .lf_lvl(lf_lvl),
    .hf_pin(high_freq_counter_pin), .lf_pin(low_freq_counter_pin));
  // short gates keep the run brief
  counter_sense #(.GATE_CYC0(21'd64), .GATE_CYC1(21'd16), .GATE_CYC2(21'd32), .GATE_CYC3(21'd48)) dut (
    .sys_clk(sys_clk), .rst(rst), .high_freq_counter_pin(high_freq_counter_pin),
    .low_freq_counter_pin(low_freq_counter_pin), .voltage_sense_pin(voltage_sense_pin), .hold_pin(hold_pin),
    .io_setup_instr(io_setup_instr), .setup_word_selector(setup_word_selector),
    .counter_setup_instr(counter_setup_instr), .count_time_instr(count_time_instr),
    .counter_control_instr(counter_control_instr), .internal_reg_input_instr(internal_reg_input_instr),
    .flag_test_instr(flag_test_instr), .clock_stop_instr(clock_stop_instr), .instr_data(instr_data),
    .reg_addr(reg_addr), .hold_enable_flag(hold_enable_flag), .read_data_q(read_data_q),
    .read_valid_q(read_valid_q), .flag_data_q(flag_data_q), .flag_valid_q(flag_valid_q),
    .count_done_flag(count_done_flag), .count_busy_q(count_busy_q), .count_value_q(count_value_q),
    .mode_q(mode_q), .hf_gp_q(hf_gp_q), .lf_gp_q(lf_gp_q), .clock_stop_q(clock_stop_q));
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic issue(input int idx, input logic [3:0] d, input logic [3:0] s = 4'h3);
    @(posedge sys_clk);
    stb <= 7'h1 << idx;
    instr_data <= d;
    reg_addr <= d;
    setup_word_selector <= s;
    @(posedge sys_clk);
    stb <= 7'h0;
    #1;
  endtask
  task automatic settle();
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 300 && count_busy_q === 1'b1; i++) @(posedge sys_clk);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    chk({mode_q, hf_gp_q, lf_gp_q, count_done_flag, clock_stop_q}, 6'h0);
    issue(FLAG_RD, 4'h0);
    chk({flag_valid_q, flag_data_q}, 5'h1c);
    issue(FLAG_RD, 4'h0);
    chk(flag_data_q, 4'h8);
  endtask
  task automatic t_gp_read();
    @(posedge sys_clk);
    hf_lvl <= 1'b1;
    lf_lvl <= 1'b1;
    issue(IO_SET, 4'h4);
    settle();
    issue(REG_RD, 4'he);
    chk({read_valid_q, read_data_q}, 5'h12);
    issue(IO_SET, 4'h8, 4'h5);
    chk({hf_gp_q, lf_gp_q}, 2'h1);
    issue(IO_SET, 4'h8);
    issue(REG_RD, 4'he);
    chk(read_data_q, 4'h1);
    issue(REG_RD, 4'h0);
    chk(read_data_q, 4'h0);
    issue(IO_SET, 4'hc);
    issue(REG_RD, 4'he);
    chk(read_data_q, 4'h3);
  endtask
  task automatic t_stop();
    issue(STOP, 4'h0);
    chk(clock_stop_q, 1'b0);
    @(posedge sys_clk);
    hold_enable_flag <= 1'b1;
    hold_pin <= 1'b0;
    settle();
    issue(STOP, 4'h0);
    chk(clock_stop_q, 1'b1);
    issue(REG_RD, 4'he);
    chk(read_data_q, 4'h0);
    @(posedge sys_clk);
    voltage_sense_pin <= 1'b0;
    settle();
    issue(FLAG_RD, 4'h0);
    chk(flag_data_q, 4'h4);
    @(posedge sys_clk);
    hold_pin <= 1'b1;
    voltage_sense_pin <= 1'b1;
    settle();
    chk(clock_stop_q, 1'b0);
  endtask
  task automatic t_count();
    logic [19:0] lo, hi;
    issue(IO_SET, 4'h0);
    issue(TIME_SET, 4'h0);
    @(posedge sys_clk);
    hf_run <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      issue(MODE_SET, 4'(m << 2));
      chk(count_busy_q, 1'b0);
      issue(START, 4'h0);
      chk({count_busy_q, count_done_flag}, 2'h2);
      wait_done();
      chk(count_done_flag, 1'b1);
      // 64 cycle gate on a 4 cycle period; lf pin is held still
      lo = (m == 0) ? 20'd15 : 20'd0;
      hi = (m == 0) ? 20'd17 : 20'd0;
      chk(count_value_q >= lo && count_value_q <= hi, 1'b1);
    end
    @(posedge sys_clk);
    lf_run <= 1'b1;
    issue(MODE_SET, 4'h8);
    chk(mode_q, 2'h2);
    issue(MODE_SET, 4'hc);
    chk(mode_q, 2'h2);
    issue(START, 4'h0);
    wait_done();
    chk(count_done_flag, 1'b1);
    // one rising edge to the next is 4 cycles, closing cycle included
    chk(count_value_q, 20'd4);
    // the other three gates: 16, 32 and 48 cycles on the 4 cycle period
    issue(MODE_SET, 4'h0);
    for (int t = 1; t < 4; t++) begin
      issue(TIME_SET, 4'(t));
      issue(START, 4'h0);
      wait_done();
      chk(count_value_q, 20'(4 * t));
    end
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    t_reset();
    t_gp_read();
    t_stop();
    t_count();
    summarize();
  end
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule

// File: pin_drive_model.sv
// square wave and level source for the two counter pins
`timescale 1ns/10ps
module pin_drive_model #(
  parameter int HALF_NS = 50
) (
  // run selects and idle levels
  input  wire  hf_run,
  input  wire  lf_run,
  input  wire  hf_lvl,
  input  wire  lf_lvl,
  // pins
  output logic hf_pin,
  output logic lf_pin
);
  // free running, so its phase is unrelated to sys_clk
  logic osc = 1'b0;
  always #(HALF_NS) osc = ~osc;
  assign hf_pin = hf_run ? osc : hf_lvl;
  assign lf_pin = lf_run ? osc : lf_lvl;
endmodule

// File: pin_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync (
  // clock and reset
  input  wire sys_clk,
  input  wire rst,
  // asynchronous pin and filtered level
  input  wire pin,
  output reg  level_q
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // a change counts once stages two and three agree
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

endmodule
